// ### fbsio_pkg.sv
// Constants, field layouts and types for the field-bus slave I/O block.
// Assumes a 100 MHz system clock; shared by the top module and the bench.
package fbsio_pkg;
	localparam int CLK_HZ = 100_000_000;
	localparam int CYC_PER_US = CLK_HZ / 1_000_000;
	// Filter base step and nibble watchdog, long counts go to top parameters
	localparam int FILT_BASE_US = 128;
	localparam int FILT_BASE_CYC = FILT_BASE_US * CYC_PER_US;
	localparam int NIB_WDOG_MS = 327;
	localparam int NIB_WDOG_CYC = NIB_WDOG_MS * (CLK_HZ / 1000);
	localparam int STB_NS = 200;
	localparam int STB_CYC = (STB_NS * CYC_PER_US + 999) / 1000;
	localparam int MUX_WIN_NS = 400;
	localparam int MUX_WIN_CYC = (MUX_WIN_NS * CYC_PER_US + 999) / 1000;
	localparam int MAGIC_BIT_NS = 20_000;
	localparam int MAGIC_BIT_CYC = (MAGIC_BIT_NS * CYC_PER_US + 999) / 1000;
	localparam int MAGIC_LEN = 8;
	localparam logic [7:0] MAGIC_PAT = 8'hA5;
	localparam int CNT_W = 26;
	localparam int SAME_ADDR_MAX = 3;
	// Stored configuration word layout
	localparam int CFG_PBIDIR = 0;
	localparam int CFG_MUX = 1;
	localparam int CFG_INVALL = 2;
	localparam int CFG_INVM = 3;
	localparam int CFG_FMASK = 7;
	localparam int CFG_FSEL = 11;
	localparam int CFG_FPIN = 14;
	localparam int CFG_FEN = 15;
	localparam int CFG_FXM = 16;
	localparam int CFG_FXV = 20;
	localparam int CFG_SYNC = 24;
	localparam int CFG_EXT = 25;
	localparam int CFG_NWD = 26;
	localparam int CFG_ADDR = 27;
	localparam logic [31:0] CFG_RST = 32'h0000_0000;
	// Register map
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STAT = 4'h4;
	localparam logic [3:0] REG_DATA = 4'h8;
	localparam logic [3:0] REG_CFG = 4'hC;
	localparam int CTRL_REINIT = 0;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_DECERR = 2'b11;
	typedef enum logic [1:0] {MODE_SLAVE, MODE_MASTER, MODE_REPEATER, MODE_MONITOR} fbsio_mode_e;
	typedef enum logic [1:0] {ACH_IDLE, ACH_MAGIC, ACH_ACTIVE} fbsio_ach_e;
endpackage

// ### fbsio_top.sv
// Mode selection and slave-mode I/O of a two-wire field-bus interface.
// Assumes a telegram decoder ahead of it and an AXI4-Lite master for status.
//
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module fbsio_top #(
	parameter int FILT_BASE = fbsio_pkg::FILT_BASE_CYC,
	parameter int NIB_WDOG = fbsio_pkg::NIB_WDOG_CYC,
	parameter int MAGIC_BIT = fbsio_pkg::MAGIC_BIT_CYC
) (
	input wire logic CLK_I,
	input wire logic SYS_RST_I,
	input wire logic NVM_MASTER_FLAG_I,
	input wire logic NVM_REPEATER_FLAG_I,
	input wire logic NVM_B_SLAVE_I,
	input wire logic [31:0] NVM_CFG_I,
	input wire logic TLG_STB_I,
	input wire logic TLG_IS_REQ_I,
	input wire logic [4:0] TLG_ADDR_I,
	input wire logic [4:0] TLG_INFO_I,
	input wire logic RSP_MAN_I,
	input wire logic DIAG_LED_I,
	input wire logic ADDR_CH_AC_I,
	input wire logic ADDR_CH_CMOS_I,
	input wire logic [3:0] DATA_IN_I,
	input wire logic [3:0] PARAM_IN_I,
	output logic [1:0] MODE_O,
	output logic RX_STB_REQ_O,
	output logic RX_STB_RSP_O,
	output logic ADDR_CH_ACTIVE_O,
	output logic ADDR_CH_AC_MODE_O,
	output logic ADDR_CH_RX_O,
	output logic DIAG_LED_O,
	output logic BUS_TX_O,
	output logic [3:0] DATA_OUT_O,
	output logic [3:0] DATA_OE_O,
	output logic DATA_STB_O,
	output logic [3:0] SEND_DATA_O,
	output logic [3:0] PARAM_OUT_O,
	output logic PARAM_OE_O,
	output logic PARAM_STB_O,
	output logic [3:0] PARAM_RSP_O,
	output logic NIB_WDOG_FAULT_O,
	input wire logic [3:0] S_AXI_AWADDR_I,
	input wire logic S_AXI_AWVALID_I,
	output logic S_AXI_AWREADY_O,
	input wire logic [31:0] S_AXI_WDATA_I,
	input wire logic [3:0] S_AXI_WSTRB_I,
	input wire logic S_AXI_WVALID_I,
	output logic S_AXI_WREADY_O,
	output logic [1:0] S_AXI_BRESP_O,
	output logic S_AXI_BVALID_O,
	input wire logic S_AXI_BREADY_I,
	input wire logic [3:0] S_AXI_ARADDR_I,
	input wire logic S_AXI_ARVALID_I,
	output logic S_AXI_ARREADY_O,
	output logic [31:0] S_AXI_RDATA_O,
	output logic [1:0] S_AXI_RRESP_O,
	output logic S_AXI_RVALID_O,
	input wire logic S_AXI_RREADY_I
);
	import fbsio_pkg::*;

	logic init_q;
	logic [31:0] cfg_q;
	logic bsel_q;
	fbsio_mode_e mode_q;
	logic wr_go, reinit;

	// Init: stored flags and settings are caught one edge after release or re-init
	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			init_q <= 1'b1;
		end else begin
			init_q <= reinit;
		end
	end

	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			cfg_q <= CFG_RST;
			bsel_q <= 1'b0;
			mode_q <= MODE_SLAVE;
		end else if (init_q) begin
			cfg_q <= NVM_CFG_I;
			bsel_q <= NVM_B_SLAVE_I;
			case ({NVM_MASTER_FLAG_I, NVM_REPEATER_FLAG_I})
				2'b10: mode_q <= MODE_MASTER;
				2'b11: mode_q <= MODE_REPEATER;
				2'b01: mode_q <= MODE_MONITOR;
				default: mode_q <= MODE_SLAVE;
			endcase
		end
	end

	wire is_slave = (mode_q == MODE_SLAVE);
	wire [4:0] my_addr = cfg_q[CFG_ADDR +: 5];
	wire ext_mode = cfg_q[CFG_EXT];

	// Receive strobes for master-side modes
	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			RX_STB_REQ_O <= 1'b0;
			RX_STB_RSP_O <= 1'b0;
		end else begin
			RX_STB_REQ_O <= TLG_STB_I & TLG_IS_REQ_I & (mode_q == MODE_MONITOR);
			RX_STB_RSP_O <= TLG_STB_I & ~TLG_IS_REQ_I & ~is_slave;
		end
	end

	// Addressing channel: path detection, magic sequence, stays until reset
	fbsio_ach_e ach_q;
	logic ac_sel_q, ac_dly_q, cm_dly_q;
	logic [CNT_W-1:0] mbit_cnt_q;
	logic [3:0] mbit_num_q;
	logic [7:0] magic_q;
	wire ach_in = ac_sel_q ? ADDR_CH_AC_I : ADDR_CH_CMOS_I;
	wire ac_fall = ac_dly_q & ~ADDR_CH_AC_I;
	wire cm_fall = cm_dly_q & ~ADDR_CH_CMOS_I;

	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			ach_q <= ACH_IDLE;
			ac_sel_q <= 1'b0;
			ac_dly_q <= 1'b1;
			cm_dly_q <= 1'b1;
			mbit_cnt_q <= '0;
			mbit_num_q <= '0;
			magic_q <= '0;
		end else begin
			ac_dly_q <= ADDR_CH_AC_I;
			cm_dly_q <= ADDR_CH_CMOS_I;
			case (ach_q)
				ACH_IDLE: begin
					if (is_slave && (ac_fall || cm_fall)) begin
						ac_sel_q <= ac_fall;
						ach_q <= ACH_MAGIC;
						mbit_cnt_q <= CNT_W'(MAGIC_BIT / 2);
						mbit_num_q <= '0;
					end
				end
				ACH_MAGIC: begin
					if (mbit_cnt_q == '0) begin
						magic_q <= {magic_q[6:0], ach_in};
						mbit_num_q <= mbit_num_q + 4'h1;
						mbit_cnt_q <= CNT_W'(MAGIC_BIT - 1);
						if (mbit_num_q == 4'(MAGIC_LEN - 1)) begin
							ach_q <= ({magic_q[6:0], ach_in} == MAGIC_PAT) ? ACH_ACTIVE : ACH_IDLE;
						end
					end else begin
						mbit_cnt_q <= mbit_cnt_q - CNT_W'(1);
					end
				end
				ACH_ACTIVE: ach_q <= ACH_ACTIVE; // Only reset leaves
				default: ach_q <= ACH_IDLE;
			endcase
		end
	end

	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			ADDR_CH_ACTIVE_O <= 1'b0;
			ADDR_CH_AC_MODE_O <= 1'b0;
			ADDR_CH_RX_O <= 1'b1;
			DIAG_LED_O <= 1'b0;
			BUS_TX_O <= 1'b0;
		end else begin
			ADDR_CH_ACTIVE_O <= (ach_q == ACH_ACTIVE);
			ADDR_CH_AC_MODE_O <= ac_sel_q;
			ADDR_CH_RX_O <= (ach_q == ACH_ACTIVE) ? ach_in : 1'b1;
			DIAG_LED_O <= (ach_q == ACH_ACTIVE) ? ~RSP_MAN_I : DIAG_LED_I;
			BUS_TX_O <= (ach_q == ACH_ACTIVE) ? 1'b0 : RSP_MAN_I;
		end
	end

	// Own telegram decode; in extended mode bit three picks A or B slave
	wire sel_ok = ~ext_mode | (TLG_INFO_I[3] == bsel_q);
	wire own = TLG_STB_I & TLG_IS_REQ_I & is_slave & (TLG_ADDR_I == my_addr) & sel_ok;
	wire own_dx = own & ~TLG_INFO_I[4];
	wire own_wp = own & TLG_INFO_I[4];
	wire any_dx = TLG_STB_I & TLG_IS_REQ_I & ~TLG_INFO_I[4];

	// Requested outputs before the fixed-level mask
	logic [3:0] req_out, out_now_q;
	always_comb begin
		req_out = TLG_INFO_I[3:0];
		if (ext_mode) begin
			req_out = {out_now_q[3], TLG_INFO_I[2:0]};
			if (cfg_q[CFG_NWD]) begin
				req_out = TLG_INFO_I[2] ? {TLG_INFO_I[1:0], out_now_q[1:0]}
					: {out_now_q[3:2], TLG_INFO_I[1:0]};
			end
		end
	end
	wire [3:0] fxm = cfg_q[CFG_FXM +: 4];
	wire [3:0] fix_out = (req_out & ~fxm) | (cfg_q[CFG_FXV +: 4] & fxm);

	// Synchronous I/O tracking
	logic [4:0] last_addr_q, sync_addr_q;
	logic sync_found_q, pend_q;
	logic [1:0] same_cnt_q;
	logic [3:0] pend_out_q;
	wire sync_bypass = ~cfg_q[CFG_SYNC] | ~sync_found_q | (same_cnt_q == 2'(SAME_ADDR_MAX));
	wire sync_hit = any_dx & sync_found_q & (TLG_ADDR_I == sync_addr_q);

	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			last_addr_q <= '0;
			sync_addr_q <= '0;
			sync_found_q <= 1'b0;
			same_cnt_q <= '0;
		end else if (init_q) begin
			sync_found_q <= 1'b0;
			same_cnt_q <= '0;
		end else if (any_dx) begin
			last_addr_q <= TLG_ADDR_I;
			if (TLG_ADDR_I < last_addr_q) begin
				sync_addr_q <= TLG_ADDR_I;
				sync_found_q <= 1'b1;
			end
			if (TLG_ADDR_I != last_addr_q) begin
				same_cnt_q <= '0;
			end else if (same_cnt_q != 2'(SAME_ADDR_MAX)) begin
				same_cnt_q <= same_cnt_q + 2'h1;
			end
		end
	end

	logic apply;
	logic [3:0] apply_val;
	always_comb begin
		apply = 1'b0;
		apply_val = fix_out;
		if (own_dx && (sync_bypass || TLG_ADDR_I == sync_addr_q)) begin
			apply = 1'b1;
		end else if (sync_hit && pend_q) begin
			apply = 1'b1;
			apply_val = pend_out_q;
		end
	end

	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			pend_q <= 1'b0;
			pend_out_q <= '0;
		end else if (own_dx && !apply) begin
			pend_q <= 1'b1;
			pend_out_q <= fix_out;
		end else if (apply) begin
			pend_q <= 1'b0;
		end
	end

	// Data port: update, strobe, then sample at strobe end
	logic [7:0] dstb_cnt_q, mux_cnt_q;
	logic [3:0] filt_val;
	wire [3:0] raw_in = cfg_q[CFG_INVALL] ? ~filt_val : (filt_val ^ cfg_q[CFG_INVM +: 4]);

	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			out_now_q <= '0;
			dstb_cnt_q <= '0;
			mux_cnt_q <= '0;
			DATA_OUT_O <= '0;
			DATA_OE_O <= '0;
			DATA_STB_O <= 1'b0;
			SEND_DATA_O <= '0;
		end else begin
			if (apply) begin
				out_now_q <= apply_val;
				DATA_OUT_O <= apply_val;
				dstb_cnt_q <= 8'(STB_CYC);
				mux_cnt_q <= 8'(MUX_WIN_CYC);
			end else begin
				if (dstb_cnt_q != '0) dstb_cnt_q <= dstb_cnt_q - 8'h1;
				if (mux_cnt_q != '0) mux_cnt_q <= mux_cnt_q - 8'h1;
			end
			DATA_STB_O <= apply | (dstb_cnt_q > 8'h1);
			if (dstb_cnt_q == 8'h1) begin
				SEND_DATA_O <= raw_in;
			end
			// Multiplex mode frees the pins so inputs can share them
			DATA_OE_O <= (!cfg_q[CFG_MUX] || apply || mux_cnt_q > 8'h1) ? 4'hF : 4'h0;
		end
	end

	// Parameter port, same phasing as the data port
	logic [7:0] pstb_cnt_q;
	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			pstb_cnt_q <= '0;
			PARAM_OUT_O <= '0;
			PARAM_OE_O <= 1'b0;
			PARAM_STB_O <= 1'b0;
			PARAM_RSP_O <= '0;
		end else begin
			if (own_wp) begin
				PARAM_OUT_O <= ext_mode ? {PARAM_OUT_O[3], TLG_INFO_I[2:0]} : TLG_INFO_I[3:0];
				pstb_cnt_q <= 8'(STB_CYC);
			end else if (pstb_cnt_q != '0) begin
				pstb_cnt_q <= pstb_cnt_q - 8'h1;
			end
			PARAM_STB_O <= own_wp | (pstb_cnt_q > 8'h1);
			// Bidirectional: release pins before sampling the answer
			PARAM_OE_O <= ~cfg_q[CFG_PBIDIR] | own_wp | (pstb_cnt_q > 8'h2);
			if (own_wp && !cfg_q[CFG_PBIDIR]) begin
				PARAM_RSP_O <= ext_mode ? {PARAM_OUT_O[3], TLG_INFO_I[2:0]} : TLG_INFO_I[3:0];
			end else if (pstb_cnt_q == 8'h1 && cfg_q[CFG_PBIDIR]) begin
				PARAM_RSP_O <= PARAM_IN_I;
			end
		end
	end

	// Polling cycle measurement between own data exchanges
	logic [CNT_W-1:0] cyc_run_q, cyc_meas_q;
	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			cyc_run_q <= '0;
			cyc_meas_q <= CNT_W'(FILT_BASE);
		end else if (own_dx) begin
			cyc_meas_q <= cyc_run_q;
			cyc_run_q <= '0;
		end else if (cyc_run_q != '1) begin
			cyc_run_q <= cyc_run_q + CNT_W'(1);
		end
	end

	// Filter time: doubling steps, or the measured cycle when the step is zero
	wire [2:0] fsel = cfg_q[CFG_FSEL +: 3];
	wire [CNT_W-1:0] filt_time = (fsel == 3'h0) ? cyc_meas_q
		: (CNT_W'(FILT_BASE) << (fsel - 3'h1));
	wire param_pin_two = PARAM_IN_I[2];
	wire filt_on = cfg_q[CFG_FPIN] ? param_pin_two : cfg_q[CFG_FEN];

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_filt
			logic [CNT_W-1:0] cnt_q;
			logic stable_q;
			always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
				if (SYS_RST_I) begin
					cnt_q <= '0;
					stable_q <= 1'b0;
				end else if (DATA_IN_I[gi] == stable_q) begin
					cnt_q <= '0;
				end else if (cnt_q >= filt_time - CNT_W'(1)) begin
					stable_q <= DATA_IN_I[gi];
					cnt_q <= '0;
				end else begin
					cnt_q <= cnt_q + CNT_W'(1);
				end
			end
			assign filt_val[gi] = (filt_on & cfg_q[CFG_FMASK + gi]) ? stable_q : DATA_IN_I[gi];
		end
	endgenerate

	// Nibble-select watchdog; a trade-off: one toggle clears the fault
	logic [CNT_W-1:0] nwd_cnt_q;
	logic nsel_q;
	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			nwd_cnt_q <= '0;
			nsel_q <= 1'b0;
			NIB_WDOG_FAULT_O <= 1'b0;
		end else if (!(ext_mode && cfg_q[CFG_NWD])) begin
			nwd_cnt_q <= '0;
			NIB_WDOG_FAULT_O <= 1'b0;
		end else if (own_dx && TLG_INFO_I[2] != nsel_q) begin
			nsel_q <= TLG_INFO_I[2];
			nwd_cnt_q <= '0;
			NIB_WDOG_FAULT_O <= 1'b0;
		end else if (nwd_cnt_q >= CNT_W'(NIB_WDOG - 1)) begin
			NIB_WDOG_FAULT_O <= 1'b1;
		end else begin
			nwd_cnt_q <= nwd_cnt_q + CNT_W'(1);
		end
	end

	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			MODE_O <= '0;
		end else begin
			MODE_O <= mode_q;
		end
	end

	// AXI4-Lite slave: write taken with both address and data present
	assign wr_go = S_AXI_AWREADY_O & S_AXI_AWVALID_I & S_AXI_WVALID_I;
	assign reinit = wr_go & (S_AXI_AWADDR_I == REG_CTRL) & S_AXI_WSTRB_I[0]
		& S_AXI_WDATA_I[CTRL_REINIT];

	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			S_AXI_AWREADY_O <= 1'b0;
			S_AXI_WREADY_O <= 1'b0;
			S_AXI_BVALID_O <= 1'b0;
			S_AXI_BRESP_O <= RESP_OKAY;
		end else begin
			S_AXI_AWREADY_O <= ~wr_go & ~S_AXI_BVALID_O & S_AXI_AWVALID_I & S_AXI_WVALID_I;
			S_AXI_WREADY_O <= ~wr_go & ~S_AXI_BVALID_O & S_AXI_AWVALID_I & S_AXI_WVALID_I;
			if (wr_go) begin
				S_AXI_BVALID_O <= 1'b1;
				S_AXI_BRESP_O <= (S_AXI_AWADDR_I[1:0] == 2'b00) ? RESP_OKAY : RESP_DECERR;
			end else if (S_AXI_BREADY_I) begin
				S_AXI_BVALID_O <= 1'b0;
			end
		end
	end

	wire rd_go = S_AXI_ARREADY_O & S_AXI_ARVALID_I;
	always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			S_AXI_ARREADY_O <= 1'b0;
			S_AXI_RVALID_O <= 1'b0;
			S_AXI_RDATA_O <= '0;
			S_AXI_RRESP_O <= RESP_OKAY;
		end else begin
			S_AXI_ARREADY_O <= ~rd_go & ~S_AXI_RVALID_O & S_AXI_ARVALID_I;
			if (rd_go) begin
				S_AXI_RVALID_O <= 1'b1;
				S_AXI_RRESP_O <= RESP_OKAY;
				case (S_AXI_ARADDR_I)
					REG_CTRL: S_AXI_RDATA_O <= '0;
					REG_STAT: S_AXI_RDATA_O <= {24'h00_0000, sync_found_q, NIB_WDOG_FAULT_O,
						ac_sel_q, (ach_q == ACH_ACTIVE), 2'b00, mode_q};
					REG_DATA: S_AXI_RDATA_O <= {16'h0000, PARAM_RSP_O, PARAM_OUT_O,
						SEND_DATA_O, out_now_q};
					REG_CFG: S_AXI_RDATA_O <= cfg_q;
					default: begin
						S_AXI_RDATA_O <= '0;
						S_AXI_RRESP_O <= RESP_DECERR;
					end
				endcase
			end else if (S_AXI_RREADY_I) begin
				S_AXI_RVALID_O <= 1'b0;
			end
		end
	end
endmodule // fbsio_top
`default_nettype wire

// ### fbsio_monitor.sv
// Port checker for the field-bus slave I/O block.
// Bound onto fbsio_top from the bench top file; sees only top ports.
`timescale 1ns/10ps
`default_nettype none
module fbsio_monitor (
	input wire logic CLK_I,
	input wire logic SYS_RST_I,
	input wire logic RSP_MAN_I,
	input wire logic [1:0] MODE_O,
	input wire logic RX_STB_REQ_O,
	input wire logic RX_STB_RSP_O,
	input wire logic ADDR_CH_ACTIVE_O,
	input wire logic ADDR_CH_RX_O,
	input wire logic DIAG_LED_O,
	input wire logic BUS_TX_O,
	input wire logic DATA_STB_O,
	input wire logic PARAM_STB_O,
	input wire logic [3:0] DATA_OE_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (SYS_RST_I);
	req_only_monitor_a: assert property (RX_STB_REQ_O |-> MODE_O == 2'h3)
		else $error("request strobe outside monitor mode");
	rsp_not_slave_a: assert property (RX_STB_RSP_O |-> MODE_O != 2'h0)
		else $error("response strobe in slave mode");
	req_pulse_a: assert property (RX_STB_REQ_O |=> !RX_STB_REQ_O)
		else $error("request strobe longer than one cycle");
	led_inverted_a: assert property (ADDR_CH_ACTIVE_O && $past(ADDR_CH_ACTIVE_O)
		|-> DIAG_LED_O == !$past(RSP_MAN_I)) else $error("led not inverted response");
	tx_quiet_a: assert property (ADDR_CH_ACTIVE_O && $past(ADDR_CH_ACTIVE_O) |-> !BUS_TX_O)
		else $error("bus transmit while channel active");
	ch_sticky_a: assert property (ADDR_CH_ACTIVE_O |=> ADDR_CH_ACTIVE_O)
		else $error("addressing channel left without reset");
	rx_idle_a: assert property (!ADDR_CH_ACTIVE_O |-> ADDR_CH_RX_O)
		else $error("channel receive not idle high");
	data_stb_len_a: assert property ($rose(DATA_STB_O) |-> ##18 DATA_STB_O ##[1:2] !DATA_STB_O)
		else $error("data strobe length wrong");
	param_stb_len_a: assert property ($rose(PARAM_STB_O) |-> ##18 PARAM_STB_O ##[1:2] !PARAM_STB_O)
		else $error("parameter strobe length wrong");
	oe_window_a: assert property ($rose(DATA_STB_O) |-> DATA_OE_O == 4'hF ##19 DATA_OE_O == 4'hF)
		else $error("outputs not driven in window");
endmodule // fbsio_monitor
`default_nettype wire

// ### fbsio_io_model.sv
// Local sensor logic on the data and parameter ports.
// Presents fresh inputs when a strobe rises, as external logic would.
`timescale 1ns/10ps
`default_nettype none
module fbsio_io_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic data_stb_i,
	input wire logic param_stb_i,
	input wire logic [3:0] nxt_data_i,
	input wire logic [3:0] nxt_param_i,
	output logic [3:0] data_in_o,
	output logic [3:0] param_in_o
);
	logic dstb_q;
	logic pstb_q;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			dstb_q <= 1'b0;
			pstb_q <= 1'b0;
			data_in_o <= 4'h0;
			param_in_o <= 4'h0;
		end else begin
			dstb_q <= data_stb_i;
			pstb_q <= param_stb_i;
			// New values well before sampling at strobe end
			if (data_stb_i && !dstb_q) data_in_o <= nxt_data_i;
			if (param_stb_i && !pstb_q) param_in_o <= nxt_param_i;
		end
	end
endmodule // fbsio_io_model
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for fbsio_top with a local I/O model.
// Short counts: filter base 16, nibble watchdog 200, magic bit 8 cycles.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fail_count++; \
	$display("wrong value at %0t: %h vs %h", $time, (a), (e)); end end
module tb_top;
	import fbsio_pkg::*;
	localparam logic [31:0] ADR = 32'h2800_0000;
	logic clk = 0, rst = 1, mf = 0, rf = 0, stb = 0, isrq = 0, rman = 0, dled = 0, ac = 1, cm = 1;
	logic awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
	logic [31:0] cfg = 0, wd = 0, rdat, rdd;
	logic [4:0] ta = 0, ti = 0;
	logic [3:0] awa = 0, ara = 0, nd = 0, np = 0, din, pin, eo, oe5, dout, doe, sd, pout, prsp;
	logic [1:0] mode, rsp, rres, bres, wrsp;
	logic rq, rs, act, acm, dstb, pstb, wdf, awr, wrdy, bv, arr, rv, poe;
	int fail_count = 0, cmp_count = 0, nq, nr;
	integer seed = 27273;
	fbsio_top #(.FILT_BASE(16), .NIB_WDOG(200), .MAGIC_BIT(8)) u_dut (.CLK_I(clk), .SYS_RST_I(rst),
		.NVM_MASTER_FLAG_I(mf), .NVM_REPEATER_FLAG_I(rf), .NVM_B_SLAVE_I(1'b0), .NVM_CFG_I(cfg),
		.TLG_STB_I(stb), .TLG_IS_REQ_I(isrq), .TLG_ADDR_I(ta), .TLG_INFO_I(ti), .RSP_MAN_I(rman),
		.DIAG_LED_I(dled), .ADDR_CH_AC_I(ac), .ADDR_CH_CMOS_I(cm), .DATA_IN_I(din),
		.PARAM_IN_I(pin), .MODE_O(mode), .RX_STB_REQ_O(rq), .RX_STB_RSP_O(rs),
		.ADDR_CH_ACTIVE_O(act), .ADDR_CH_AC_MODE_O(acm), .ADDR_CH_RX_O(), .DIAG_LED_O(),
		.BUS_TX_O(), .DATA_OUT_O(dout), .DATA_OE_O(doe), .DATA_STB_O(dstb), .SEND_DATA_O(sd),
		.PARAM_OUT_O(pout), .PARAM_OE_O(poe), .PARAM_STB_O(pstb), .PARAM_RSP_O(prsp),
		.NIB_WDOG_FAULT_O(wdf), .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv),
		.S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wv),
		.S_AXI_WREADY_O(wrdy), .S_AXI_BRESP_O(bres), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(br),
		.S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
		.S_AXI_RDATA_O(rdd), .S_AXI_RRESP_O(rres), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rr));
	fbsio_io_model u_io (.clk_i(clk), .rst_i(rst), .data_stb_i(dstb), .param_stb_i(pstb),
		.nxt_data_i(nd), .nxt_param_i(np), .data_in_o(din), .param_in_o(pin));
	initial begin
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		rman <= 1'($random(seed));
		dled <= 1'($random(seed));
	end
	task automatic tick(int k);
		repeat (k) @(posedge clk);
	endtask
	task print_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task wr(logic [3:0] a, logic [31:0] d);
		logic ad, dn;
		@(posedge clk);
		awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
		ad = 1'b0;
		dn = 1'b0;
		// Each channel is let go at its own handshake edge
		do begin
			@(posedge clk);
			if (awr) ad = 1'b1;
			if (wrdy) dn = 1'b1;
			if (ad) awv <= 1'b0;
			if (dn) wv <= 1'b0;
		end while (!(ad && dn));
		do @(posedge clk); while (!bv);
		wrsp = bres;
		br <= 1'b0;
	endtask
	task rd(logic [3:0] a);
		@(posedge clk);
		ara <= a; arv <= 1'b1; rr <= 1'b1;
		do @(posedge clk); while (!arr);
		arv <= 1'b0;
		do @(posedge clk); while (!rv);
		rdat = rdd; rsp = rres; rr <= 1'b0;
	endtask
	// Mode and config only move after reset release or on a re-init request
	task init(logic [31:0] c, logic m, logic r);
		@(posedge clk);
		cfg <= c; mf <= m; rf <= r;
		wr(REG_CTRL, 32'h0000_0001);
		tick(3);
	endtask
	// 26 cycles per telegram keeps strobes whole
	task tg(logic q, logic [4:0] a, logic [4:0] i);
		@(posedge clk);
		stb <= 1'b1; isrq <= q; ta <= a; ti <= i;
		@(posedge clk);
		stb <= 1'b0; nq = 0; nr = 0;
		for (int k = 0; k < 24; k++) begin
			@(posedge clk);
			nq += rq; nr += rs;
			if (k == 4) oe5 = doe;
		end
	endtask
	task magic(logic use_ac, logic [7:0] p);
		@(posedge clk);
		if (use_ac) ac <= 1'b0; else cm <= 1'b0;
		for (int b = 7; b >= 0; b--) begin
			@(posedge clk);
			if (use_ac) ac <= p[b]; else cm <= p[b];
			tick(b == 7 ? 6 : 7);
		end
		@(posedge clk);
		ac <= 1'b1; cm <= 1'b1;
		tick(10);
	endtask
	function automatic logic [3:0] f_send(logic [31:0] c, logic [3:0] d);
		return c[CFG_INVALL] ? ~d : d ^ c[CFG_INVM+:4];
	endfunction
	function automatic logic [3:0] f_out(logic [31:0] c, logic [3:0] p, logic [4:0] i);
		logic [3:0] o;
		o = i[3:0];
		if (c[CFG_NWD]) o = i[2] ? {i[1:0], p[1:0]} : {p[3:2], i[1:0]};
		return (o & ~c[CFG_FXM+:4]) | (c[CFG_FXV+:4] & c[CFG_FXM+:4]);
	endfunction
	initial begin
		logic [31:0] c;
		logic [4:0] d;
		logic [3:0] old;
		tick(16);
		rst <= 1'b0;
		tick(3);
		for (int m = 0; m < 4; m++) begin
			init(ADR, m == 1 || m == 2, m >= 2);
			`CHK(wrsp, RESP_OKAY)
			`CHK(mode, m[1:0])
			rd(REG_STAT);
			`CHK(rdat[1:0], m[1:0])
			tg(1'b0, 5'h07, 5'h03);
			`CHK(nr, int'(m != 0))
			tg(1'b1, 5'h07, 5'h03);
			`CHK(nq, int'(m == 3))
			@(posedge clk);
			mf <= ~mf; rf <= ~rf;
			tick(4);
			`CHK(mode, m[1:0])
		end
		$display("test modes finished");
		for (int k = 0; k < 8; k++) begin
			c = ADR | (32'($random(seed)) & 32'h00FF_007F);
			if (c[CFG_INVALL]) c[CFG_INVM+:4] = 4'h0;
			init(c, 1'b0, 1'b0);
			d = {1'b0, 4'($random(seed))};
			nd <= 4'($random(seed));
			np <= 4'($random(seed));
			tg(1'b1, 5'h05, d);
			`CHK(dout, f_out(c, 4'h0, d))
			`CHK(sd, f_send(c, nd))
			`CHK(oe5, 4'hF)
			tg(1'b1, 5'h06, ~d);
			`CHK(doe, c[CFG_MUX] ? 4'h0 : 4'hF)
			`CHK(dout, f_out(c, 4'h0, d))
			d[4] = 1'b1;
			tg(1'b1, 5'h05, d);
			`CHK(pout, d[3:0])
			`CHK(prsp, c[CFG_PBIDIR] ? np : d[3:0])
			`CHK(poe, ~c[CFG_PBIDIR])
		end
		$display("test data port finished");
		// Step 0 last: the measured cycle is long, so the filtered bits keep their old level
		for (int s = 2; s >= 0; s--) begin
			init(ADR | 32'h0000_8280 | (32'(s) << CFG_FSEL), 1'b0, 1'b0);
			old = 4'($random(seed));
			nd <= old;
			tg(1'b1, 5'h05, 5'h00);
			tick(80);
			nd <= ~old;
			tg(1'b1, 5'h05, 5'h00);
			`CHK(sd, s == 1 ? ~old : (~old & 4'hA) | (old & 4'h5))
		end
		$display("test filter finished");
		c = 32'h2E00_0000;
		init(c, 1'b0, 1'b0);
		eo = 4'h0;
		for (int k = 0; k < 6; k++) begin
			d = {2'b00, k[0], 2'($random(seed))};
			tg(1'b1, 5'h05, d);
			eo = f_out(c, eo, d);
			if (k > 0) `CHK(dout, eo)
		end
		`CHK(wdf, 1'b0)
		tg(1'b1, 5'h05, 5'h0F);
		`CHK(dout, eo)
		repeat (10) tg(1'b1, 5'h05, 5'h01);
		`CHK(wdf, 1'b1)
		tg(1'b1, 5'h05, 5'h04);
		`CHK(wdf, 1'b0)
		$display("test extended finished");
		init(ADR | 32'h0100_0000, 1'b0, 1'b0);
		tg(1'b1, 5'h05, 5'h03);
		`CHK(dout, 4'h3)
		tg(1'b1, 5'h02, 5'h00);
		tg(1'b1, 5'h05, 5'h0C);
		`CHK(dout, 4'h3)
		tg(1'b1, 5'h02, 5'h00);
		`CHK(dout, 4'hC)
		repeat (4) tg(1'b1, 5'h05, 5'h09);
		`CHK(dout, 4'hC)
		tg(1'b1, 5'h05, 5'h09);
		`CHK(dout, 4'h9)
		$display("test sync finished");
		magic(1'b0, 8'h5A);
		`CHK(act, 1'b0)
		magic(1'b0, MAGIC_PAT);
		`CHK(act, 1'b1)
		`CHK(acm, 1'b0)
		init(ADR, 1'b0, 1'b0);
		`CHK(act, 1'b1)
		rst <= 1'b1;
		tick(2);
		rst <= 1'b0;
		tick(3);
		`CHK(act, 1'b0)
		magic(1'b1, MAGIC_PAT);
		`CHK(acm, 1'b1)
		$display("test channel finished");
		rd(4'h2);
		`CHK(rsp, RESP_DECERR)
		rd(REG_CTRL);
		`CHK(rdat, 32'h0000_0000)
		$display("test register bus finished");
		print_verdict;
	end
	initial begin
		tick(20000);
		fail_count++;
		print_verdict;
	end
endmodule // tb_top
bind fbsio_top fbsio_monitor u_mon (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .RSP_MAN_I(RSP_MAN_I),
	.MODE_O(MODE_O), .RX_STB_REQ_O(RX_STB_REQ_O), .RX_STB_RSP_O(RX_STB_RSP_O),
	.ADDR_CH_ACTIVE_O(ADDR_CH_ACTIVE_O), .ADDR_CH_RX_O(ADDR_CH_RX_O), .DIAG_LED_O(DIAG_LED_O),
	.BUS_TX_O(BUS_TX_O), .DATA_STB_O(DATA_STB_O), .PARAM_STB_O(PARAM_STB_O),
	.DATA_OE_O(DATA_OE_O));
`default_nettype wire
